//--- hw/host_ctrl.sv
// functional state, remote wake-up and command status logic of the host controller
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "host_ctrl_defs.svh"

module host_ctrl #(
    parameter int SOF_DELAY_CYCLES = `SOF_DELAY_CYC,
    parameter int PORT_RST_CYCLES  = `PORT_RST_CYC
) (
    input  wire logic                      pclk,            // 50 MHz system clock
    input  wire logic                      presetn,         // hardware reset, async
    input  wire logic                      psel,            // apb select
    input  wire logic                      penable,         // apb access phase
    input  wire logic                      pwrite,          // apb direction
    input  wire logic [11:0]               paddr,           // apb byte address
    input  wire logic [31:0]               pwdata,          // apb write data
    output logic      [31:0]               prdata,          // apb read data
    output logic                           pready,          // apb ready
    output logic                           pslverr,         // apb error, unmapped
    input  wire logic                      resume_pin,      // downstream resume, async
    input  wire logic                      resume_detected, // resume flag of status reg
    input  wire logic                      eof_pulse,       // end-of-frame point
    input  wire logic                      periodic_busy,   // periodic list unfinished
    output host_ctrl_pkg::fstate_t         functional_state, // current state field
    output logic                           sof_enable,      // frame generation running
    output logic                           remote_wakeup,   // wake-up to host system
    output logic                           overrun_pulse,   // sets overrun status flag
    output logic                           root_hub_reset,  // root hub reset
    output logic                           port_reset       // reset on downstream ports
);
    import host_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addr_is(input logic [11:0] a, input logic [7:0] idx);
        addr_is = (a == {2'h0, idx, 2'h0});
    endfunction : addr_is

    function automatic logic [31:0] ctrl_word(input state_t s);
        ctrl_word = 32'h0;
        ctrl_word[`CTRL_WE_BIT] = s.wake_en;
        ctrl_word[`CTRL_WC_BIT] = s.wake_conn;
        ctrl_word[`CTRL_FS_MSB:`CTRL_FS_LSB] = s.fstate;
    endfunction : ctrl_word

    function automatic logic [31:0] cmd_word(input state_t s);
        cmd_word = 32'h0;
        cmd_word[`CMD_SOC_MSB:`CMD_SOC_LSB] = s.soc;
        cmd_word[`CMD_HCR_BIT] = s.hcr;
    endfunction : cmd_word

    localparam state_t ST_RESET = '{
        fstate: FS_RESET,
        soc:    `SOC_RESET,
        phase:  PH_HUB,
        rh_rst: `HUB_RST_RESET,
        default: '0
    };

    state_t st_ff;
    state_t nxt_st;
    logic   setup;
    logic   acc;
    logic   wr_ctl;
    logic   wr_cmd;
    logic   rd_ctl;
    logic   rd_cmd;
    logic   ovr_ev;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        setup  = psel & ~penable;
        // zero wait states: ready rises in the first access cycle
        acc    = psel & penable & st_ff.ready;
        wr_ctl = acc & pwrite & addr_is(paddr, `CTRL_WR_IDX);
        wr_cmd = acc & pwrite & addr_is(paddr, `CMD_WR_IDX);
        rd_ctl = ~pwrite & addr_is(paddr, `CTRL_RD_IDX);
        rd_cmd = ~pwrite & addr_is(paddr, `CMD_RD_IDX);
        ovr_ev = eof_pulse & periodic_busy;

        // resume pin synchroniser
        nxt_st.res_s1 = resume_pin;
        nxt_st.res_s2 = st_ff.res_s1;

        // bus answer, read data captured in setup
        nxt_st.ready = setup;
        nxt_st.err   = 1'b0;
        if (setup) begin
            if (rd_ctl) begin
                nxt_st.rdata = ctrl_word(st_ff);
            end else if (rd_cmd) begin
                nxt_st.rdata = cmd_word(st_ff);
            end else if (pwrite && (addr_is(paddr, `CTRL_WR_IDX) ||
                                    addr_is(paddr, `CMD_WR_IDX))) begin
                nxt_st.rdata = 32'h0;
            end else begin
                nxt_st.rdata = 32'h0;
                nxt_st.err   = 1'b1;
            end
        end

        // software writes to control
        if (wr_ctl) begin
            nxt_st.wake_en   = pwdata[`CTRL_WE_BIT];
            nxt_st.wake_conn = pwdata[`CTRL_WC_BIT];
            nxt_st.fstate    = fstate_t'(pwdata[`CTRL_FS_MSB:`CTRL_FS_LSB]);
        end

        // only suspended state moves on its own; resume beats a same-cycle write
        if (st_ff.fstate == FS_SUSPENDED && st_ff.res_s2) begin
            nxt_st.fstate = FS_RESUMING;
        end

        // frame start delay, restarts on every entry into operational
        if (st_ff.fstate != FS_OPERATIONAL) begin
            nxt_st.sof_cnt = 16'h0;
            nxt_st.sof_run = 1'b0;
        end else if (!st_ff.sof_run) begin
            if (st_ff.sof_cnt == 16'(SOF_DELAY_CYCLES - 1)) begin
                nxt_st.sof_run = 1'b1;
            end else begin
                nxt_st.sof_cnt = st_ff.sof_cnt + 16'h1;
            end
        end

        // overrun counts even when the status flag is already set
        nxt_st.ovr = ovr_ev;
        if (ovr_ev) begin
            nxt_st.soc = st_ff.soc + 2'h1;
        end

        // software reset takes one cycle; wake connected survives it
        if (st_ff.hcr) begin
            nxt_st.fstate  = FS_RESET;
            nxt_st.wake_en = 1'b0;
            nxt_st.soc     = `SOC_RESET;
            nxt_st.sof_cnt = 16'h0;
            nxt_st.sof_run = 1'b0;
            nxt_st.hcr     = 1'b0;
        end

        // write-one-to-set; a new command beats the completion clear
        if (wr_cmd && pwdata[`CMD_HCR_BIT]) begin
            nxt_st.hcr = 1'b1;
        end

        // no path from wake enable into interrupt events
        nxt_st.rwake = st_ff.wake_en & resume_detected;

        // hardware-reset sequence: root hub first, then the ports
        case (st_ff.phase)
            PH_HUB: begin
                nxt_st.rh_rst  = 1'b0;
                nxt_st.prt_rst = 1'b1;
                nxt_st.prt_cnt = 20'h0;
                nxt_st.phase   = PH_PORTS;
            end
            PH_PORTS: begin
                if (st_ff.prt_cnt == 20'(PORT_RST_CYCLES - 1)) begin
                    nxt_st.prt_rst = 1'b0;
                    nxt_st.phase   = PH_DONE;
                end else begin
                    nxt_st.prt_cnt = st_ff.prt_cnt + 20'h1;
                end
            end
            default: begin
                nxt_st.rh_rst  = 1'b0;
                nxt_st.prt_rst = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata           = st_ff.rdata;
    assign pready           = st_ff.ready;
    assign pslverr          = st_ff.err;
    assign functional_state = st_ff.fstate;
    assign sof_enable       = st_ff.sof_run;
    assign remote_wakeup    = st_ff.rwake;
    assign overrun_pulse    = st_ff.ovr;
    assign root_hub_reset   = st_ff.rh_rst;
    assign port_reset       = st_ff.prt_rst;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_wake_signal: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_ff.wake_en && resume_detected) |=> remote_wakeup
    ) else $error("remote wake-up missing");

    a_wake_no_event: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(eof_pulse && periodic_busy) |=> !overrun_pulse
    ) else $error("event raised without cause");

    a_conn_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_ff.hcr && !wr_ctl) |=> $stable(st_ff.wake_conn)
    ) else $error("software reset altered wake connected");

    a_sof_delay: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(sof_enable) |-> $past(st_ff.sof_cnt) == 16'(SOF_DELAY_CYCLES - 1)
            && functional_state == FS_OPERATIONAL
    ) else $error("frames started at wrong time");

    a_sof_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        (functional_state != FS_OPERATIONAL) |=> !sof_enable
    ) else $error("frames running outside operational");

    a_state_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (functional_state != FS_SUSPENDED && !wr_ctl && !st_ff.hcr)
            |=> $stable(functional_state)
    ) else $error("state changed without software");

    a_resume_move: assert property (
        @(posedge pclk) disable iff (!presetn)
        (functional_state == FS_SUSPENDED && st_ff.res_s2 && !st_ff.hcr)
            |=> functional_state == FS_RESUMING
    ) else $error("resume not taken");

    a_swreset_st: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.hcr |=> functional_state == FS_RESET
    ) else $error("software reset missed state");

    a_hub_order: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(root_hub_reset) |-> port_reset
    ) else $error("ports not reset after hub");

    a_cmd_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_cmd && pwdata[`CMD_HCR_BIT])
            |=> st_ff.hcr ##1 (!st_ff.hcr || $past(wr_cmd && pwdata[`CMD_HCR_BIT]))
    ) else $error("command bit not set");

    a_cmd_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && rd_cmd) |=> prdata == $past(cmd_word(st_ff))
    ) else $error("command status read wrong");

    a_soc_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ovr_ev && !st_ff.hcr) |=> st_ff.soc == $past(st_ff.soc) + 2'h1 && overrun_pulse
    ) else $error("overrun count wrong");

    ////////////////////////////////////////////////////////////////////////////
    // bus answer: exactly one access cycle, refusals flagged and harmless

    a_ready_follows: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready
    ) else $error("no ready after setup");

    a_ready_single: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready
    ) else $error("ready held too long");

    a_err_refused: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !rd_ctl && !rd_cmd && !(pwrite && (addr_is(paddr, `CTRL_WR_IDX) ||
            addr_is(paddr, `CMD_WR_IDX)))) |=> pready && pslverr
    ) else $error("bad access not refused");

    a_read_ok: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && (rd_ctl || rd_cmd)) |=> pready && !pslverr
    ) else $error("good read refused");

    a_write_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && pwrite) |=> prdata == 32'h0
    ) else $error("write returned data");

    // a refused write must leave the control bits as they were
    a_refused_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pslverr && !st_ff.hcr)
            |=> $stable(st_ff.wake_en) && $stable(st_ff.wake_conn)
    ) else $error("refused write took effect");

    a_ctrl_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && rd_ctl) |=> prdata == {21'h0, $past(st_ff.wake_en), $past(st_ff.wake_conn),
            1'h0, $past(st_ff.fstate), 6'h0}
    ) else $error("control read wrong");

    a_ctrl_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ctl |=> st_ff.wake_conn == $past(pwdata[`CTRL_WC_BIT])
            && (st_ff.wake_en == $past(pwdata[`CTRL_WE_BIT]) || $past(st_ff.hcr))
    ) else $error("control write lost");

    ////////////////////////////////////////////////////////////////////////////
    // events, wake-up and reset side effects

    a_wake_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(st_ff.wake_en && resume_detected) |=> !remote_wakeup
    ) else $error("remote wake-up without cause");

    a_ovr_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (eof_pulse && periodic_busy) |=> overrun_pulse
    ) else $error("overrun flag missing");

    a_soc_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!ovr_ev && !st_ff.hcr) |=> $stable(st_ff.soc)
    ) else $error("overrun count moved without overrun");

    a_cmd_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!(wr_cmd && pwdata[`CMD_HCR_BIT]) && !st_ff.hcr) |=> !st_ff.hcr
    ) else $error("command bit set without write");

    // software reset must clear its own state but never reach the hub or the ports
    a_swreset_clr: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.hcr |=> st_ff.soc == `SOC_RESET && !sof_enable && !st_ff.wake_en
    ) else $error("software reset left state behind");

    a_swreset_hub: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_ff.hcr && !root_hub_reset && !port_reset) |=> !root_hub_reset && !port_reset
    ) else $error("software reset reached the ports");

    a_hub_once: assert property (
        @(posedge pclk) disable iff (!presetn)
        !root_hub_reset |=> !root_hub_reset
    ) else $error("hub reset outside hardware reset");

    a_sof_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sof_enable && functional_state == FS_OPERATIONAL && !st_ff.hcr) |=> sof_enable
    ) else $error("frames stopped while operational");

endmodule : host_ctrl

//--- pkg/host_ctrl_defs.svh
// register map, field positions, reset values and timing of the host control block
`ifndef HOST_CTRL_DEFS_SVH
`define HOST_CTRL_DEFS_SVH

// register indices (command codes); byte address is four times the index
`define CTRL_RD_IDX      8'h01
`define CTRL_WR_IDX      8'h81
`define CMD_RD_IDX       8'h02
`define CMD_WR_IDX       8'h82

`define CTRL_WE_BIT      10
`define CTRL_WC_BIT      9
`define CTRL_FS_MSB      7
`define CTRL_FS_LSB      6
`define CMD_HCR_BIT      0
`define CMD_SOC_MSB      17
`define CMD_SOC_LSB      16

`define SOC_RESET        2'h0
`define HUB_RST_RESET    1'h1

`define PCLK_PERIOD_NS   20
`define SOF_DELAY_NS     1000000
`define PORT_RST_NS      10000000
`define SOF_DELAY_CYC    (`SOF_DELAY_NS / `PCLK_PERIOD_NS)
`define PORT_RST_CYC     (`PORT_RST_NS / `PCLK_PERIOD_NS)

`endif

//--- pkg/host_ctrl_pkg.sv
// types of the host control block
package host_ctrl_pkg;

    // declaration order gives 00 reset, 01 resuming, 10 operational, 11 suspended
    typedef enum logic [1:0] {
        FS_RESET,
        FS_RESUMING,
        FS_OPERATIONAL,
        FS_SUSPENDED
    } fstate_t;

    typedef enum logic [1:0] {
        PH_HUB,
        PH_PORTS,
        PH_DONE
    } rst_phase_t;

    typedef struct packed {
        fstate_t    fstate;
        logic       wake_en;
        logic       wake_conn;
        logic       hcr;
        logic [1:0] soc;
        logic [15:0] sof_cnt;
        logic       sof_run;
        logic       rwake;
        logic       ovr;
        rst_phase_t phase;
        logic [19:0] prt_cnt;
        logic       rh_rst;
        logic       prt_rst;
        logic       res_s1;
        logic       res_s2;
        logic [31:0] rdata;
        logic       ready;
        logic       err;
    } state_t;

endpackage : host_ctrl_pkg

//--- sim/downstream_port.sv
// downstream port model: sends resume signalling toward the host
`timescale 1ns/1ps
module downstream_port (
    input  wire logic resume_req, // bench asks for resume
    output logic      resume_pin  // resume level on the port
);
    // offset from pclk on purpose, so the host synchroniser is exercised
    assign #7 resume_pin = resume_req;
endmodule : downstream_port

//--- sim/usb_host_state_and_command_regs_test.sv
// self-checking bench of the host control block
`timescale 1ns/1ps
module usb_host_state_and_command_regs_test;
    import host_ctrl_pkg::*;
    localparam int SOF_CYC = 8;
    localparam int PRT_CYC = 4;
    typedef struct {
        logic        wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic        err;
    } row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        resume_req, resume_pin, resume_detected, eof_pulse, periodic_busy;
    logic        sof_enable, remote_wakeup, overrun_pulse, root_hub_reset, port_reset;
    fstate_t     functional_state;
    int          n_mismatch, n_compared, k;
    row_t        rows [9];

    host_ctrl #(.SOF_DELAY_CYCLES(SOF_CYC), .PORT_RST_CYCLES(PRT_CYC)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .resume_pin, .resume_detected, .eof_pulse,
        .periodic_busy, .functional_state, .sof_enable, .remote_wakeup,
        .overrun_pulse, .root_hub_reset, .port_reset);
    downstream_port port_model (.resume_req, .resume_pin);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // n rising edges, then look at settled outputs
    task automatic at(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : at

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        // request stands until the edge that sees ready; data taken at that edge only
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] q);
        apb(1'b0, a, 32'h0);
        chk(what, q, rd);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, resume_req} = 5'h0;
        {resume_detected, eof_pulse, periodic_busy} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rows = '{'{0, 12'h004, 32'h0, 32'h0, 0}, '{0, 12'h008, 32'h0, 32'h0, 0},
                 '{1, 12'h204, 32'hffff_ffff, 32'h0, 0}, '{0, 12'h004, 32'h0, 32'h6c0, 0},
                 '{1, 12'h208, 32'h0, 32'h0, 0}, '{0, 12'h00c, 32'h0, 32'h0, 1},
                 '{0, 12'h204, 32'h0, 32'h0, 1}, '{1, 12'h004, 32'h1, 32'h0, 1},
                 '{0, 12'h004, 32'h0, 32'h6c0, 0}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[j]) begin
            apb(rows[j].wr, rows[j].a, rows[j].d);
            chk("pslverr", {31'h0, rows[j].err}, {31'h0, er});
            if (!rows[j].wr) chk("prdata", rows[j].q, rd);
        end
        $display("register table done");

        apb(1'b1, 12'h204, 32'h0000_0080);
        at(SOF_CYC - 1);
        chk("sof_enable early", 32'h0, {31'h0, sof_enable});
        at(1);
        chk("sof_enable", 32'h1, {31'h0, sof_enable});
        apb(1'b1, 12'h204, 32'h0000_0400);
        at(1);
        chk("sof_enable off", 32'h0, {31'h0, sof_enable});
        @(posedge pclk);
        resume_detected <= 1'b1;
        at(1);
        chk("remote_wakeup", 32'h1, {31'h0, remote_wakeup});
        chk("overrun_pulse quiet", 32'h0, {31'h0, overrun_pulse});
        apb(1'b1, 12'h204, 32'h0);
        at(1);
        chk("remote_wakeup off", 32'h0, {31'h0, remote_wakeup});
        @(posedge pclk);
        resume_detected <= 1'b0;
        $display("frame start and wake-up done");

        apb(1'b1, 12'h204, 32'h0000_00c0);
        @(posedge pclk);
        resume_req <= 1'b1;
        for (k = 0; k < 6 && functional_state !== FS_RESUMING; k++) at(0);
        chk("state resuming", 32'h1, {30'h0, functional_state});
        apb(1'b1, 12'h204, 32'h0000_0080);
        at(5);
        chk("state held", 32'h2, {30'h0, functional_state});
        @(posedge pclk);
        resume_req <= 1'b0;
        $display("resume done");

        for (k = 0; k < 5; k++) begin
            @(posedge pclk);
            eof_pulse <= 1'b1;
            periodic_busy <= 1'b1;
            @(posedge pclk);
            eof_pulse <= 1'b0;
            at(0);
            chk("overrun_pulse", 32'h1, {31'h0, overrun_pulse});
        end
        @(posedge pclk);
        eof_pulse <= 1'b1;
        periodic_busy <= 1'b0;
        @(posedge pclk);
        eof_pulse <= 1'b0;
        at(0);
        chk("no overrun", 32'h0, {31'h0, overrun_pulse});
        rdchk("overrun count", 12'h008, 32'h0001_0000);
        $display("overrun done");

        apb(1'b1, 12'h204, 32'h0000_06c0);
        apb(1'b1, 12'h208, 32'h0);
        rdchk("command kept", 12'h008, 32'h0001_0000);
        apb(1'b1, 12'h208, 32'h1);
        at(1);
        chk("hub reset", 32'h0, {31'h0, root_hub_reset | port_reset});
        rdchk("control after soft reset", 12'h004, 32'h0000_0200);
        rdchk("command after soft reset", 12'h008, 32'h0);
        $display("software reset done");

        apb(1'b1, 12'h204, 32'h0000_0280);
        @(posedge pclk);
        presetn <= 1'b0;
        at(0);
        chk("root_hub_reset", 32'h1, {31'h0, root_hub_reset});
        chk("state in reset", 32'h0, {30'h0, functional_state});
        @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 8 && port_reset !== 1'b1; k++) at(0);
        for (k = 0; k < 20 && port_reset === 1'b1; k++) at(0);
        chk("port reset cycles", PRT_CYC, k);
        rdchk("control after hard reset", 12'h004, 32'h0);
        $display("hardware reset done");
        test_done();
    end
endmodule : usb_host_state_and_command_regs_test
